// >>> hdl/amp_ctrl_pkg.sv
package amp_ctrl_pkg;

    // register offsets on the control port
    localparam logic [7:0] ADDR_PART_IDENTITY = 8'h00;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h01;
    localparam logic [7:0] ADDR_DIGITAL_PATH_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_VOLUME_CONFIGURATION = 8'h03;
    localparam logic [7:0] ADDR_LEFT_VOLUME = 8'h04;

    // reset values
    localparam logic [7:0] RST_POWER_CONTROL = 8'hFD;
    localparam logic [7:0] RST_DIGITAL_PATH_CONTROL = 8'h14;
    localparam logic [7:0] RST_VOLUME_CONFIGURATION = 8'h80;
    localparam logic [7:0] RST_LEFT_VOLUME = 8'hCF;

    // bits that software may change; reserved bits keep their reset value
    localparam logic [7:0] WMASK_POWER_CONTROL = 8'hFF;
    localparam logic [7:0] WMASK_DIGITAL_PATH_CONTROL = 8'hBF;
    localparam logic [7:0] WMASK_VOLUME_CONFIGURATION = 8'h83;
    localparam logic [7:0] WMASK_LEFT_VOLUME = 8'hFF;

    // field positions
    localparam int PWR_CLIP_MSB = 7;
    localparam int PWR_CLIP_LSB = 2;
    localparam int PWR_SLEEP_BIT = 1;
    localparam int PWR_RUN_BIT = 0;
    localparam int DIG_HPF_BYPASS_BIT = 7;
    localparam int DIG_BOOST_MSB = 5;
    localparam int DIG_BOOST_LSB = 4;
    localparam int DIG_SPEED_BIT = 3;
    localparam int DIG_FORMAT_MSB = 2;
    localparam int DIG_FORMAT_LSB = 0;
    localparam int VC_FADE_BIT = 7;
    localparam int VC_MUTE_RIGHT_BIT = 1;
    localparam int VC_MUTE_LEFT_BIT = 0;

    // volume code map, half-decibel steps
    localparam logic [7:0] VOL_ZERO_DB_CODE = 8'hCF;
    localparam logic [7:0] VOL_MUTE_BELOW_CODE = 8'h07;
    localparam logic [4:0] BOOST_STEP_DB = 5'h06;

    // control port
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2D;
    localparam logic [7:0] PART_ID_DEFAULT = 8'h5A; // value is arbitrary
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int FADE_STEP_NS = 10000;
    localparam int FADE_STEP_CYCLES = FADE_STEP_NS / CLK_PERIOD_NS;

endpackage

// >>> hdl/volume_fader.sv
`timescale 1ns/1ns
`default_nettype none

module volume_fader #(
    parameter logic [15:0] STEP_CYCLES = 16'(amp_ctrl_pkg::FADE_STEP_CYCLES)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic [7:0] target_code,
    input wire logic fade_enable,
    // applied code
    output logic [7:0] applied_code
);

    typedef struct packed {
        logic [15:0] tick;
        logic [7:0] code;
    } fader_state_t;

    fader_state_t s_reg;
    fader_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (!fade_enable || s_reg.code == target_code) begin
            s_next.code = target_code;
            s_next.tick = 16'h0000;
        end else if (s_reg.tick >= STEP_CYCLES - 16'h0001) begin
            // one half-decibel step toward the target
            s_next.tick = 16'h0000;
            if (s_reg.code < target_code) begin
                s_next.code = s_reg.code + 8'h01;
            end else begin
                s_next.code = s_reg.code - 8'h01;
            end
        end else begin
            s_next.tick = s_reg.tick + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{tick: 16'h0000, code: amp_ctrl_pkg::RST_LEFT_VOLUME};
        end else begin
            s_reg <= s_next;
        end
    end

    assign applied_code = s_reg.code;

endmodule

`default_nettype wire

// >>> hdl/audio_amp_control_registers.sv
`timescale 1ns/1ns
`default_nettype none

module audio_amp_control_registers #(
    parameter logic [6:0] DEV_ADDR = amp_ctrl_pkg::DEV_ADDR_DEFAULT,
    // identity value is arbitrary
    parameter logic [7:0] PART_ID = amp_ctrl_pkg::PART_ID_DEFAULT,
    parameter logic [15:0] FADE_STEP_CYCLES = 16'(amp_ctrl_pkg::FADE_STEP_CYCLES)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // two-wire control port
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_drive_n,
    // power stage controls
    output logic [5:0] clip_threshold_upper_bits,
    output logic sleep_mode,
    output logic power_stage_enable,
    output logic speaker_supply_enable,
    // digital path controls
    output logic hpf_bypass,
    output logic [4:0] digital_boost_db,
    output logic double_speed,
    output logic [2:0] input_format,
    // volume controls
    output logic fade_enable,
    output logic mute_right,
    output logic mute_left,
    output logic [8:0] left_gain_half_db
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_RX,
        ST_ACK_RX,
        ST_TX,
        ST_ACK_TX
    } port_state_t;

    typedef struct packed {
        port_state_t st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic rw;
        logic ptr_phase;
        logic ack_ok;
        logic [7:0] ptr;
        logic scl_q;
        logic sda_q;
        logic sda_drive_n;
        logic [7:0] pwr;
        logic [7:0] dig;
        logic [7:0] vcfg;
        logic [7:0] lvol;
        logic pstage_en;
        logic supply_en;
        logic [4:0] boost_db;
        logic mute_l;
        logic [8:0] gain;
    } ctrl_state_t;

    localparam ctrl_state_t RESET_STATE = '{
        st: ST_IDLE,
        sh: 8'h00,
        cnt: 4'h0,
        rw: 1'b0,
        ptr_phase: 1'b0,
        ack_ok: 1'b0,
        ptr: 8'h00,
        scl_q: 1'b1,
        sda_q: 1'b1,
        sda_drive_n: 1'b1,
        pwr: amp_ctrl_pkg::RST_POWER_CONTROL,
        dig: amp_ctrl_pkg::RST_DIGITAL_PATH_CONTROL,
        vcfg: amp_ctrl_pkg::RST_VOLUME_CONFIGURATION,
        lvol: amp_ctrl_pkg::RST_LEFT_VOLUME,
        pstage_en: 1'b1,
        supply_en: 1'b1,
        boost_db: 5'h06,
        mute_l: 1'b0,
        gain: 9'h000
    };

    ctrl_state_t s_reg;
    ctrl_state_t s_next;

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] rd_byte;
    logic [7:0] rd_next;
    logic [7:0] applied_code;

    // read mux; unmapped offsets read zero
    function automatic logic [7:0] reg_read(input ctrl_state_t s, input logic [7:0] a);
        case (a)
            amp_ctrl_pkg::ADDR_PART_IDENTITY: reg_read = PART_ID;
            amp_ctrl_pkg::ADDR_POWER_CONTROL: reg_read = s.pwr;
            amp_ctrl_pkg::ADDR_DIGITAL_PATH_CONTROL: reg_read = s.dig;
            amp_ctrl_pkg::ADDR_VOLUME_CONFIGURATION: reg_read = s.vcfg;
            amp_ctrl_pkg::ADDR_LEFT_VOLUME: reg_read = s.lvol;
            default: reg_read = 8'h00;
        endcase
    endfunction

    // keep bits outside the write mask
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d, input logic [7:0] m);
        merge = (old & ~m) | (d & m);
    endfunction

    function automatic logic [4:0] boost_to_db(input logic [1:0] b);
        boost_to_db = 5'({3'h0, b} * amp_ctrl_pkg::BOOST_STEP_DB);
    endfunction

    volume_fader #(
        .STEP_CYCLES(FADE_STEP_CYCLES)
    ) u_fader (
        .clk(clk),
        .rst_n(rst_n),
        .target_code(s_reg.lvol),
        .fade_enable(s_reg.vcfg[amp_ctrl_pkg::VC_FADE_BIT]),
        .applied_code(applied_code)
    );

    assign scl_rise = ~s_reg.scl_q & scl_in;
    assign scl_fall = s_reg.scl_q & ~scl_in;
    assign start_seen = s_reg.scl_q & scl_in & s_reg.sda_q & ~sda_in;
    assign stop_seen = s_reg.scl_q & scl_in & ~s_reg.sda_q & sda_in;
    assign rd_byte = reg_read(s_reg, s_reg.ptr);
    assign rd_next = reg_read(s_reg, s_reg.ptr + 8'h01);

    always_comb begin
        s_next = s_reg;
        s_next.scl_q = scl_in;
        s_next.sda_q = sda_in;
        case (s_reg.st)
            ST_IDLE: begin
                s_next.sda_drive_n = 1'b1;
            end
            ST_ADDR: begin
                if (scl_rise) begin
                    s_next.sh = {s_reg.sh[6:0], sda_in};
                    s_next.cnt = s_reg.cnt + 4'h1;
                end
                if (scl_fall && s_reg.cnt == amp_ctrl_pkg::BITS_PER_BYTE) begin
                    s_next.cnt = 4'h0;
                    if (s_reg.sh[7:1] == DEV_ADDR) begin
                        s_next.sda_drive_n = 1'b0;
                        s_next.rw = s_reg.sh[0];
                        s_next.ptr_phase = 1'b1;
                        s_next.st = ST_ACK_ADDR;
                    end else begin
                        s_next.st = ST_IDLE;
                    end
                end
            end
            ST_ACK_ADDR: begin
                if (scl_fall) begin
                    if (s_reg.rw) begin
                        // read after repeated start sends the pointed register
                        s_next.sh = rd_byte;
                        s_next.sda_drive_n = rd_byte[7];
                        s_next.st = ST_TX;
                    end else begin
                        s_next.sda_drive_n = 1'b1;
                        s_next.st = ST_RX;
                    end
                end
            end
            ST_RX: begin
                if (scl_rise) begin
                    s_next.sh = {s_reg.sh[6:0], sda_in};
                    s_next.cnt = s_reg.cnt + 4'h1;
                end
                if (scl_fall && s_reg.cnt == amp_ctrl_pkg::BITS_PER_BYTE) begin
                    s_next.cnt = 4'h0;
                    s_next.sda_drive_n = 1'b0;
                    s_next.st = ST_ACK_RX;
                    if (s_reg.ptr_phase) begin
                        s_next.ptr = s_reg.sh;
                        s_next.ptr_phase = 1'b0;
                    end else begin
                        s_next.ptr = s_reg.ptr + 8'h01;
                        // identity and unmapped offsets ignore writes
                        case (s_reg.ptr)
                            amp_ctrl_pkg::ADDR_POWER_CONTROL: begin
                                s_next.pwr = merge(s_reg.pwr, s_reg.sh, amp_ctrl_pkg::WMASK_POWER_CONTROL);
                            end
                            amp_ctrl_pkg::ADDR_DIGITAL_PATH_CONTROL: begin
                                s_next.dig = merge(s_reg.dig, s_reg.sh,
                                    amp_ctrl_pkg::WMASK_DIGITAL_PATH_CONTROL);
                            end
                            amp_ctrl_pkg::ADDR_VOLUME_CONFIGURATION: begin
                                s_next.vcfg = merge(s_reg.vcfg, s_reg.sh,
                                    amp_ctrl_pkg::WMASK_VOLUME_CONFIGURATION);
                            end
                            amp_ctrl_pkg::ADDR_LEFT_VOLUME: begin
                                s_next.lvol = merge(s_reg.lvol, s_reg.sh, amp_ctrl_pkg::WMASK_LEFT_VOLUME);
                            end
                            default: begin
                                s_next.ptr = s_reg.ptr + 8'h01;
                            end
                        endcase
                    end
                end
            end
            ST_ACK_RX: begin
                if (scl_fall) begin
                    s_next.sda_drive_n = 1'b1;
                    s_next.st = ST_RX;
                end
            end
            ST_TX: begin
                if (scl_fall) begin
                    if (s_reg.cnt == amp_ctrl_pkg::BITS_PER_BYTE - 4'h1) begin
                        s_next.cnt = 4'h0;
                        s_next.sda_drive_n = 1'b1;
                        s_next.st = ST_ACK_TX;
                    end else begin
                        s_next.sh = {s_reg.sh[6:0], 1'b0};
                        s_next.sda_drive_n = s_reg.sh[6];
                        s_next.cnt = s_reg.cnt + 4'h1;
                    end
                end
            end
            ST_ACK_TX: begin
                if (scl_rise) begin
                    s_next.ack_ok = ~sda_in;
                end
                if (scl_fall) begin
                    if (s_reg.ack_ok) begin
                        s_next.ptr = s_reg.ptr + 8'h01;
                        s_next.sh = rd_next;
                        s_next.sda_drive_n = rd_next[7];
                        s_next.st = ST_TX;
                    end else begin
                        // not-acknowledge ends the read
                        s_next.st = ST_IDLE;
                    end
                end
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase
        if (start_seen) begin
            s_next.st = ST_ADDR;
            s_next.cnt = 4'h0;
            s_next.sda_drive_n = 1'b1;
        end
        if (stop_seen) begin
            s_next.st = ST_IDLE;
            s_next.sda_drive_n = 1'b1;
        end
        // power, boost and mute-bit controls follow the registers at the same edge; gain follows the fader output a clock later
        s_next.supply_en = s_next.pwr[amp_ctrl_pkg::PWR_RUN_BIT];
        s_next.pstage_en = s_next.pwr[amp_ctrl_pkg::PWR_RUN_BIT]
            & ~s_next.pwr[amp_ctrl_pkg::PWR_SLEEP_BIT];
        s_next.boost_db = boost_to_db(
            s_next.dig[amp_ctrl_pkg::DIG_BOOST_MSB:amp_ctrl_pkg::DIG_BOOST_LSB]);
        s_next.mute_l = s_next.vcfg[amp_ctrl_pkg::VC_MUTE_LEFT_BIT]
            | (applied_code < amp_ctrl_pkg::VOL_MUTE_BELOW_CODE);
        s_next.gain = 9'({1'b0, applied_code}) - 9'({1'b0, amp_ctrl_pkg::VOL_ZERO_DB_CODE});
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= RESET_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    // open-drain line: only ever pulled low
    assign sda_out = 1'b0;
    assign sda_drive_n = s_reg.sda_drive_n;
    assign clip_threshold_upper_bits = s_reg.pwr[amp_ctrl_pkg::PWR_CLIP_MSB:amp_ctrl_pkg::PWR_CLIP_LSB];
    assign sleep_mode = s_reg.pwr[amp_ctrl_pkg::PWR_SLEEP_BIT];
    assign power_stage_enable = s_reg.pstage_en;
    assign speaker_supply_enable = s_reg.supply_en;
    assign hpf_bypass = s_reg.dig[amp_ctrl_pkg::DIG_HPF_BYPASS_BIT];
    assign digital_boost_db = s_reg.boost_db;
    assign double_speed = s_reg.dig[amp_ctrl_pkg::DIG_SPEED_BIT];
    assign input_format = s_reg.dig[amp_ctrl_pkg::DIG_FORMAT_MSB:amp_ctrl_pkg::DIG_FORMAT_LSB];
    assign fade_enable = s_reg.vcfg[amp_ctrl_pkg::VC_FADE_BIT];
    assign mute_right = s_reg.vcfg[amp_ctrl_pkg::VC_MUTE_RIGHT_BIT];
    assign mute_left = s_reg.mute_l;
    assign left_gain_half_db = s_reg.gain;

endmodule

`default_nettype wire

// >>> verification/amp_host.sv
`timescale 1ns/1ns
`default_nettype none
module amp_host (
    // clock
    input wire logic clk,
    // two-wire bus
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // each bus phase lasts four clocks
    task automatic st(input logic c, input logic l);
        scl = c;
        sda_low = l;
        repeat (4) @(negedge clk);
    endtask
    task automatic start();
        st(scl, 1'b0);
        st(1'b1, 1'b0);
        st(1'b1, 1'b1);
        st(1'b0, 1'b1);
    endtask
    task automatic stop();
        st(1'b0, 1'b1);
        st(1'b1, 1'b1);
        st(1'b1, 1'b0);
    endtask
    // data set while clock low, sampled while clock high
    task automatic bitx(input logic b, output logic r);
        st(1'b0, !b);
        st(1'b1, !b);
        r = sda;
        st(1'b0, !b);
    endtask
    task automatic byte_x(input logic [7:0] d, input logic k, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(!k, a);
    endtask
    task automatic xfer(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d, input logic rd,
                        output logic [7:0] q, output logic ok);
        logic [2:0] a;
        logic n;
        start();
        byte_x({dev, 1'b0}, 1'b0, q, a[0]);
        byte_x(p, 1'b0, q, a[1]);
        if (rd) begin
            start();
            byte_x({dev, 1'b1}, 1'b0, q, a[2]);
            byte_x(8'hFF, 1'b0, q, n);
        end else begin
            byte_x(d, 1'b0, q, a[2]);
        end
        stop();
        ok = (a === 3'h0);
    endtask
endmodule
`default_nettype wire

// >>> verification/amp_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none
module amp_regs_chk #(
    parameter logic [15:0] FADE_STEP_CYCLES = 16'h00C8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire logic scl_in,
    input wire logic sda_drive_n,
    input wire logic [5:0] clip_threshold_upper_bits,
    input wire logic sleep_mode,
    input wire logic power_stage_enable,
    input wire logic speaker_supply_enable,
    input wire logic [4:0] digital_boost_db,
    input wire logic [2:0] input_format,
    input wire logic fade_enable,
    input wire logic mute_left,
    input wire logic [8:0] left_gain_half_db
);
    logic [15:0] since_reg;
    // cycles since the applied gain last moved
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_reg <= 16'h0000;
        end else begin
            since_reg <= $changed(left_gain_half_db) ? 16'h0000 : since_reg + 16'(since_reg != 16'hFFFF);
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    psu_enable_a: assert property ($past(rst_n) |-> power_stage_enable == (speaker_supply_enable && !sleep_mode))
        else $error("power stage enable wrong");
    boost_values_a: assert property (digital_boost_db inside {5'h00, 5'h06, 5'h0C, 5'h12})
        else $error("boost value illegal");
    low_mute_a: assert property ($signed(left_gain_half_db) < -200 |-> mute_left)
        else $error("low code not muted");
    gain_range_a: assert property ($signed(left_gain_half_db) >= -207 && $signed(left_gain_half_db) <= 48)
        else $error("gain out of range");
    fade_step_a: assert property (fade_enable && $past(fade_enable, 2) && $changed(left_gain_half_db) |->
        9'(left_gain_half_db - $past(left_gain_half_db)) inside {9'h001, 9'h1FF}) else $error("fade step too big");
    fade_hold_a: assert property (fade_enable && $past(fade_enable, 2) && $changed(left_gain_half_db) |->
        since_reg >= FADE_STEP_CYCLES - 16'h0001) else $error("fade step too soon");
    ack_timing_a: assert property ($changed(sda_drive_n) |-> $past(scl_in, 2) && !$past(scl_in))
        else $error("data line moved off clock fall");
    write_timing_a: assert property ($changed({clip_threshold_upper_bits, input_format}) |-> !sda_drive_n)
        else $error("field changed outside write");
endmodule
bind audio_amp_control_registers amp_regs_chk #(.FADE_STEP_CYCLES(FADE_STEP_CYCLES)) i_chk (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_drive_n(sda_drive_n),
    .clip_threshold_upper_bits(clip_threshold_upper_bits), .sleep_mode(sleep_mode),
    .power_stage_enable(power_stage_enable), .speaker_supply_enable(speaker_supply_enable),
    .digital_boost_db(digital_boost_db), .input_format(input_format), .fade_enable(fade_enable),
    .mute_left(mute_left), .left_gain_half_db(left_gain_half_db));
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    // arbitrary identity value
    localparam logic [7:0] ID = 8'hA5;
    localparam logic [6:0] DEV = amp_ctrl_pkg::DEV_ADDR_DEFAULT;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, sda_low, drive_n, sda, so, sleep, psu, sup, hpf, dbl, fade, mr, ml, ok;
    logic [5:0] clip;
    logic [4:0] boost;
    logic [2:0] fmt;
    logic [8:0] gain;
    logic [7:0] q;
    int fails = 0;
    int compares = 0;
    always #25 clk = ~clk;
    // open-drain wire: the device puts sda_out on the pin while it drives
    assign sda = !sda_low && (drive_n || so);
    amp_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    audio_amp_control_registers #(.PART_ID(ID), .FADE_STEP_CYCLES(16'h0004)) i_dut (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(so), .sda_drive_n(drive_n),
        .clip_threshold_upper_bits(clip), .sleep_mode(sleep), .power_stage_enable(psu),
        .speaker_supply_enable(sup), .hpf_bypass(hpf), .digital_boost_db(boost), .double_speed(dbl),
        .input_format(fmt), .fade_enable(fade), .mute_right(mr), .mute_left(ml), .left_gain_half_db(gain));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("ERROR t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        i_host.xfer(DEV, p, d, 1'b0, q, ok);
        chk(ok, 1'b1);
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        i_host.xfer(DEV, p, 8'h00, 1'b1, q, ok);
        chk({ok, q}, {1'b1, e});
    endtask
    task automatic chk_defaults();
        chk({clip, sleep, psu, sup, hpf, boost, dbl, fmt}, {6'h3F, 3'b011, 1'b0, 5'h06, 1'b0, 3'h4});
        chk({fade, mr, ml, gain}, {3'b100, 9'h000});
    endtask
    task automatic t_ident();
        rd(8'h02, 8'h14);
        rd(8'h03, 8'h80);
        rd(8'h04, 8'hCF);
        chk_defaults();
        wr(8'h00, 8'h00);
        wr(8'h05, 8'hFF);
        rd(8'h00, ID);
        rd(8'h05, 8'h00);
        i_host.xfer(DEV ^ 7'h01, 8'h01, 8'h00, 1'b0, q, ok);
        chk(ok, 1'b0);
        rd(8'h01, 8'hFD);
        $display("identity and reset test done");
    endtask
    task automatic t_power();
        logic [7:0] v [4] = '{8'h00, 8'hA6, 8'h81, 8'h03};
        foreach (v[i]) begin
            wr(8'h01, v[i]);
            chk({clip, sleep, sup, psu}, {v[i][7:2], v[i][1], v[i][0], v[i][0] & ~v[i][1]});
        end
        $display("power test done");
    endtask
    task automatic t_digital();
        logic [2:0] c;
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            c = 3'(i);
            d = {c[0], 1'b1, c[1:0], c[1], c};
            wr(8'h02, d);
            rd(8'h02, d & 8'hBF);
            chk({hpf, boost, dbl, fmt}, {d[7], 5'(6 * d[5:4]), d[3], c});
        end
        $display("digital test done");
    endtask
    task automatic t_volume();
        wr(8'h03, 8'hFF);
        rd(8'h03, 8'h83);
        chk({fade, mr, ml}, 3'h7);
        wr(8'h03, 8'h00);
        chk({fade, mr, ml}, 3'h0);
        $display("volume test done");
    endtask
    task automatic t_left();
        logic [7:0] v [5] = '{8'hFF, 8'hCF, 8'h07, 8'h06, 8'h00};
        logic [9:0] e [5] = '{10'h030, 10'h000, 10'h138, 10'h337, 10'h331};
        foreach (v[i]) begin
            wr(8'h04, v[i]);
            chk({ml, gain}, e[i]);
        end
        $display("left volume test done");
    endtask
    task automatic t_fade();
        wr(8'h03, 8'h80);
        wr(8'h04, 8'h30);
        chk(gain == 9'h161, 1'b0);
        repeat (300) @(negedge clk);
        chk(gain, 9'h161);
        $display("fade test done");
    endtask
    task automatic t_reset();
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk_defaults();
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk_defaults();
        rd(8'h01, 8'hFD);
        rd(8'h02, 8'h14);
        rd(8'h04, 8'hCF);
        $display("mid-run reset test done");
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        t_ident();
        t_power();
        t_digital();
        t_volume();
        t_left();
        t_fade();
        t_reset();
        test_done();
    end
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        test_done();
    end
endmodule
`default_nettype wire
